/* File: verilog/sat_regs.svh */
// Register offsets, reset values, field limits and timing counts of the
// servo auxiliary and auto-tuning parameter bank.
// Assumes inclusion by bare name from design files under verilog/.
`ifndef SAT_REGS_SVH
`define SAT_REGS_SVH

// ----------------------------------------------------------------------
// Word addresses
// ----------------------------------------------------------------------
`define SAT_ADDR_AUX      16'h023c
`define SAT_ADDR_RESP     16'h023e
`define SAT_ADDR_MODE     16'h0240
`define SAT_ADDR_FLAG     16'h0242
`define SAT_ADDR_OVSPD    16'h0244

// ----------------------------------------------------------------------
// Reset values
// ----------------------------------------------------------------------
`define SAT_RST_AUX       16'h0000
`define SAT_RST_RESP      16'h0050
`define SAT_RST_MODE      16'h0000
`define SAT_RST_FLAG      16'h0000
`define SAT_RST_OVSPD     16'h1388

// ----------------------------------------------------------------------
// Field limits
// ----------------------------------------------------------------------
`define SAT_AUX_MIN       16'hfff8
`define SAT_AUX_MAX       16'h0008
`define SAT_RESP_MIN      16'h0001
`define SAT_RESP_MAX      16'h03e8
`define SAT_BAND_LOW      16'h0032
`define SAT_BAND_MED      16'h00fa
`define SAT_BAND_HIGH     16'h0352
`define SAT_MODE_MAX      16'h0002
`define SAT_FLAG_MAX      16'h0001
`define SAT_OVSPD_MIN     16'h0001
`define SAT_OVSPD_MAX     16'h1388

// ----------------------------------------------------------------------
// Timing: inertia store period in minutes at a 250 MHz clock
// ----------------------------------------------------------------------
`define SAT_STORE_MIN     30
`define SAT_CLK_MHZ       250
`define SAT_STORE_CYCLES  (64'd60 * 64'd1000000 * `SAT_CLK_MHZ * `SAT_STORE_MIN)

`endif

/* File: verilog/sat_pkg.sv */
// Types shared by the parameter bank and its helpers.
// Assumes sat_regs.svh supplies the numeric constants.
package sat_pkg;

	// Tuning mode codes
	typedef enum logic [1:0] {
		SAT_TUNE_MANUAL,
		SAT_TUNE_AUTO,
		SAT_TUNE_SEMI
	} sat_tune_type;

	// Stiffness band from the response level
	typedef enum logic [1:0] {
		SAT_BAND_LOW_S,
		SAT_BAND_MED_S,
		SAT_BAND_HIGH_S,
		SAT_BAND_XHIGH_S
	} sat_band_type;

	// Parameter access request from keypad or link
	typedef struct packed {
		logic        wr;
		logic        rd;
		logic [15:0] addr;
		logic [15:0] wdata;
	} sat_req_type;

	// Tuned gain set handed to the control loops
	typedef struct packed {
		logic [15:0] posGain;
		logic [15:0] spdGain;
		logic [15:0] spdIntComp;
		logic [15:0] antiIntfGain;
	} sat_gain_type;

endpackage

/* File: verilog/sat_range_check.sv */
// Signed or unsigned window check used to accept or reject a parameter write.
// Assumes both bounds are 16-bit values of the same signedness as the data.
module sat_range_check #(
	parameter bit SIGNED_CMP = 1'b0
) (
	// Value and bounds
	input  wire logic [15:0] value,
	input  wire logic [15:0] lowBound,
	input  wire logic [15:0] highBound,
	// Result
	output wire logic        inRange
);

	// Signed compare is needed only for the auxiliary selector
	wire logic geLow;
	wire logic leHigh;
	assign geLow  = SIGNED_CMP ? ($signed(value) >= $signed(lowBound)) : (value >= lowBound);
	assign leHigh = SIGNED_CMP ? ($signed(value) <= $signed(highBound)) : (value <= highBound);
	assign inRange = geLow && leHigh;

endmodule

/* File: verilog/sat_speed_monitor.sv */
// Overspeed detector comparing commanded and actual speed.
// Assumes both speeds are signed r/min samples on the same clock.
module sat_speed_monitor (
	// Clock and reset
	input  wire logic        clk,
	input  wire logic        rstn,
	// Speeds and limit
	input  wire logic [15:0] speedCmd,
	input  wire logic [15:0] speedAct,
	input  wire logic [15:0] threshold,
	input  wire logic        enable,
	// Fault
	output logic             overspeedFault
);

	// Absolute speed error, one bit wider so it cannot wrap
	wire logic signed [16:0] diffSigned;
	wire logic        [16:0] diffAbs;
	wire logic               tooFast;
	assign diffSigned = $signed({speedCmd[15], speedCmd}) - $signed({speedAct[15], speedAct});
	assign diffAbs    = diffSigned[16] ? 17'(-diffSigned) : 17'(diffSigned);
	assign tooFast    = enable && (diffAbs > {1'b0, threshold});

	// Registered so the fault output is glitch free
	always_ff @(posedge clk or negedge rstn) begin
		if (!rstn) begin
			overspeedFault <= 1'b0;
		end else begin
			overspeedFault <= tooFast;
		end
	end

endmodule

/* File: verilog/sat_param_bank.sv */
// Auxiliary and auto-tuning parameter bank of a servo drive.
// Assumes a keypad/link controller issuing one-cycle requests on clk,
// and estimator and loop logic on the same clock.
`include "sat_regs.svh"

// Functional notes
// - Selector 1 forces servo-on by software regardless of external input.
// - Selector 5 blocks nonvolatile commits; values vanish at power-down.
// - Selector 6 simulates: no motion, servo-on off, only external faults.
// - Selector 7 enters high-speed scope mode, disables link time-out.
// - Writing 8 backs up all parameters, shows indication, allowed while on.
// - -1,-5,-6,-7 lock their positive codes; range -8..+8; others reserved.
// - Selector 0 disables all functions; selector clears at every power-up.
// - Response level 1..1000 Hz, resets to 80, drives position response in modes 1 and 2.
// - Response level maps to four stiffness bands; used per tuning mode.
// - Tuning mode: 0 manual, 1 continuous auto, 2 semi-auto.
// - Manual gains writable; switching from mode 1 or 2 to mode 0 loads tuned gains.
// - Switching from mode 1 to mode 0 copies only position, speed and damping gains.
// - Auto mode stores estimated inertia every 30 minutes.
// - Semi-auto stable estimate stops estimation, stores inertia, sets flag.
// - Excess inertia in semi-auto clears flag and resumes estimation.
// - Writing flag 0 restarts estimation; 0 means estimate not complete.
// - Speed error above overspeed threshold raises the overspeed fault.
module sat_param_bank #(
	parameter longint unsigned STORE_CYCLES = `SAT_STORE_CYCLES
) (
	// Clock and reset
	input  wire logic                 clk,
	input  wire logic                 rstn,
	// Parameter access from keypad or link
	input  wire sat_pkg::sat_req_type req,
	output logic [15:0]               rdata,
	output logic                      rvalid,
	output wire logic                 wrAck,
	output wire logic                 wrReject,
	// Servo and fault interface
	input  wire logic                 servoOnExt,
	output wire logic                 servoOnSignal,
	output wire logic                 motorEnable,
	output wire logic                 motorFaultMask,
	input  wire logic [15:0]          speedCmd,
	input  wire logic [15:0]          speedAct,
	output wire logic                 overspeedFault,
	// Storage, display and link
	output wire logic                 nvCommitEnable,
	output logic                      nvBackupPulse,
	output logic                      backupDisplay,
	output wire logic                 scopeMode,
	output wire logic                 timeoutDisable,
	// Tuning and inertia estimator
	output wire sat_pkg::sat_band_type stiffnessBand,
	output wire logic [15:0]          positionResponse,
	output wire logic                 estimatorRun,
	input  wire logic                 inertiaStable,
	input  wire logic                 inertiaExcess,
	input  wire logic [15:0]          inertiaEstimate,
	output logic [15:0]               loadInertiaValue,
	output logic                      inertiaStore,
	input  wire sat_pkg::sat_gain_type measuredGains,
	output logic                      gainLoad,
	output logic                      gainLoadFull
);

	// ------------------------------------------------------------------
	// Parameter storage
	// ------------------------------------------------------------------
	logic [15:0]           auxReg;
	logic [15:0]           respReg;
	sat_pkg::sat_tune_type modeReg;
	logic                  flagReg;
	logic [15:0]           ovspdReg;
	logic [15:0]           lockReg;     // Bit n locks code n
	logic [63:0]           storeCntReg;
	logic                  backupSeenReg;

	// ------------------------------------------------------------------
	// Address decode and range checks
	// ------------------------------------------------------------------
	wire logic hitAux;
	wire logic hitResp;
	wire logic hitMode;
	wire logic hitFlag;
	wire logic hitOvspd;
	wire logic auxOk;
	wire logic respOk;
	wire logic ovspdOk;
	wire logic modeOk;
	wire logic flagOk;
	wire logic auxLocked;
	wire logic hitAny;
	wire logic valueOk;
	assign hitAux   = req.addr == `SAT_ADDR_AUX;
	assign hitResp  = req.addr == `SAT_ADDR_RESP;
	assign hitMode  = req.addr == `SAT_ADDR_MODE;
	assign hitFlag  = req.addr == `SAT_ADDR_FLAG;
	assign hitOvspd = req.addr == `SAT_ADDR_OVSPD;
	assign hitAny   = hitAux | hitResp | hitMode | hitFlag | hitOvspd;

	sat_range_check #(.SIGNED_CMP(1'b1)) auxChk (
		.value    (req.wdata),
		.lowBound (`SAT_AUX_MIN),
		.highBound(`SAT_AUX_MAX),
		.inRange  (auxOk)
	);
	sat_range_check #(.SIGNED_CMP(1'b0)) respChk (
		.value    (req.wdata),
		.lowBound (`SAT_RESP_MIN),
		.highBound(`SAT_RESP_MAX),
		.inRange  (respOk)
	);
	sat_range_check #(.SIGNED_CMP(1'b0)) ovspdChk (
		.value    (req.wdata),
		.lowBound (`SAT_OVSPD_MIN),
		.highBound(`SAT_OVSPD_MAX),
		.inRange  (ovspdOk)
	);

	// Positive code 1..7 is refused while its lock is set
	assign auxLocked = !req.wdata[15] && (req.wdata[15:4] == 12'h000)
		&& lockReg[req.wdata[3:0]];
	assign modeOk    = req.wdata <= `SAT_MODE_MAX;
	assign flagOk    = req.wdata <= `SAT_FLAG_MAX;
	assign valueOk   = (hitAux && auxOk && !auxLocked) || (hitResp && respOk)
		|| (hitMode && modeOk) || (hitFlag && flagOk) || (hitOvspd && ovspdOk);
	assign wrAck     = req.wr && valueOk;
	assign wrReject  = req.wr && !valueOk;

	// ------------------------------------------------------------------
	// Auxiliary function decode
	// ------------------------------------------------------------------
	wire logic auxForceOn;
	wire logic auxVolatile;
	wire logic auxSim;
	wire logic auxScope;
	wire logic auxBackupWr;
	assign auxForceOn  = auxReg == 16'h0001;
	assign auxVolatile = auxReg == 16'h0005;
	assign auxSim      = auxReg == 16'h0006;
	assign auxScope    = auxReg == 16'h0007;
	assign auxBackupWr = wrAck && hitAux && (req.wdata == 16'h0008);

	// Simulation wins: no servo-on and no motion while simulating
	assign servoOnSignal  = !auxSim && (auxForceOn || servoOnExt);
	assign motorEnable    = servoOnSignal;
	assign motorFaultMask = auxSim;
	assign nvCommitEnable = !auxVolatile;
	assign scopeMode      = auxScope;
	assign timeoutDisable = auxScope;

	// Selector and lockouts; reset clears to 0, all functions off
	always_ff @(posedge clk or negedge rstn) begin
		if (!rstn) begin
			auxReg  <= `SAT_RST_AUX;
			lockReg <= 16'h0000;
		end else if (wrAck && hitAux) begin
			auxReg <= req.wdata;
			case (req.wdata)
				16'hffff: lockReg[1] <= 1'b1;
				16'hfffb: lockReg[5] <= 1'b1;
				16'hfffa: lockReg[6] <= 1'b1;
				16'hfff9: lockReg[7] <= 1'b1;
				default:  lockReg    <= lockReg;
			endcase
		end
	end

	// Backup pulse and display; allowed regardless of servo-on
	always_ff @(posedge clk or negedge rstn) begin
		if (!rstn) begin
			nvBackupPulse <= 1'b0;
			backupDisplay <= 1'b0;
			backupSeenReg <= 1'b0;
		end else begin
			nvBackupPulse <= auxBackupWr;
			backupSeenReg <= backupSeenReg | auxBackupWr;
			backupDisplay <= (auxReg == 16'h0008) && (backupSeenReg || auxBackupWr);
		end
	end

	// ------------------------------------------------------------------
	// Response level and stiffness band
	// ------------------------------------------------------------------
	assign stiffnessBand = (respReg <= `SAT_BAND_LOW)  ? sat_pkg::SAT_BAND_LOW_S  :
	                       (respReg <= `SAT_BAND_MED)  ? sat_pkg::SAT_BAND_MED_S  :
	                       (respReg <= `SAT_BAND_HIGH) ? sat_pkg::SAT_BAND_HIGH_S :
	                                                     sat_pkg::SAT_BAND_XHIGH_S;
	// Position response follows speed response only while tuning runs
	assign positionResponse = (modeReg == sat_pkg::SAT_TUNE_MANUAL) ? 16'h0000 : respReg;

	// Response level and overspeed threshold
	always_ff @(posedge clk or negedge rstn) begin
		if (!rstn) begin
			respReg  <= `SAT_RST_RESP;
			ovspdReg <= `SAT_RST_OVSPD;
		end else begin
			if (wrAck && hitResp)
				respReg <= req.wdata;
			if (wrAck && hitOvspd)
				ovspdReg <= req.wdata;
		end
	end

	// ------------------------------------------------------------------
	// Tuning mode and gain copy-back
	// ------------------------------------------------------------------
	wire logic                  modeWr;
	wire sat_pkg::sat_tune_type modeNext;
	assign modeWr   = wrAck && hitMode;
	assign modeNext = sat_pkg::sat_tune_type'(req.wdata[1:0]);

	// Switching auto to manual copies three gains; semi-auto to manual copies all
	always_ff @(posedge clk or negedge rstn) begin
		if (!rstn) begin
			modeReg      <= sat_pkg::SAT_TUNE_MANUAL;
			gainLoad     <= 1'b0;
			gainLoadFull <= 1'b0;
		end else begin
			gainLoad     <= modeWr && modeNext == sat_pkg::SAT_TUNE_MANUAL
				&& modeReg != sat_pkg::SAT_TUNE_MANUAL;
			gainLoadFull <= modeWr && modeNext == sat_pkg::SAT_TUNE_MANUAL
				&& modeReg == sat_pkg::SAT_TUNE_SEMI;
			if (modeWr)
				modeReg <= modeNext;
		end
	end

	// ------------------------------------------------------------------
	// Inertia estimation, periodic store and stable flag
	// ------------------------------------------------------------------
	wire logic storeDue;
	wire logic flagClrWr;
	wire logic semiDone;
	assign storeDue  = (modeReg == sat_pkg::SAT_TUNE_AUTO) && (storeCntReg == STORE_CYCLES - 64'd1);
	assign flagClrWr = wrAck && hitFlag && (req.wdata[0] == 1'b0);
	assign semiDone  = (modeReg == sat_pkg::SAT_TUNE_SEMI) && !flagReg && inertiaStable
		&& !inertiaExcess;
	// Semi-auto stops once stable; auto never stops
	assign estimatorRun = (modeReg == sat_pkg::SAT_TUNE_AUTO)
		|| ((modeReg == sat_pkg::SAT_TUNE_SEMI) && !flagReg);

	// Store timer restarts whenever auto mode is left
	always_ff @(posedge clk or negedge rstn) begin
		if (!rstn) begin
			storeCntReg <= 64'd0;
		end else if (modeReg != sat_pkg::SAT_TUNE_AUTO || storeDue) begin
			storeCntReg <= 64'd0;
		end else begin
			storeCntReg <= storeCntReg + 64'd1;
		end
	end

	// Hardware set wins over a software clear in the same cycle
	always_ff @(posedge clk or negedge rstn) begin
		if (!rstn) begin
			flagReg          <= 1'b0;
			inertiaStore     <= 1'b0;
			loadInertiaValue <= 16'h0000;
		end else begin
			inertiaStore <= storeDue || semiDone;
			if (storeDue || semiDone)
				loadInertiaValue <= inertiaEstimate;
			if (semiDone)
				flagReg <= 1'b1;
			else if ((modeReg == sat_pkg::SAT_TUNE_SEMI) && inertiaExcess)
				flagReg <= 1'b0;
			else if (flagClrWr)
				flagReg <= 1'b0;
			else if (wrAck && hitFlag)
				flagReg <= req.wdata[0];
		end
	end

	// ------------------------------------------------------------------
	// Overspeed monitor, idle in simulation
	// ------------------------------------------------------------------
	sat_speed_monitor spdMon (
		.clk           (clk),
		.rstn          (rstn),
		.speedCmd      (speedCmd),
		.speedAct      (speedAct),
		.threshold     (ovspdReg),
		.enable        (!auxSim),
		.overspeedFault(overspeedFault)
	);

	// ------------------------------------------------------------------
	// Read path; unmapped addresses read zero
	// ------------------------------------------------------------------
	wire logic [15:0] rdMux;
	assign rdMux = hitAux   ? auxReg :
	               hitResp  ? respReg :
	               hitMode  ? {14'h0000, modeReg} :
	               hitFlag  ? {15'h0000, flagReg} :
	               hitOvspd ? ovspdReg : 16'h0000;

	always_ff @(posedge clk or negedge rstn) begin
		if (!rstn) begin
			rdata  <= 16'h0000;
			rvalid <= 1'b0;
		end else begin
			rvalid <= req.rd;
			if (req.rd)
				rdata <= hitAny ? rdMux : 16'h0000;
		end
	end

	// ------------------------------------------------------------------
	// Checks
	// ------------------------------------------------------------------
	sim_servo_off_a: assert property (@(posedge clk) disable iff (!rstn)
		auxSim |-> !servoOnSignal && !motorEnable)
		else $error("servo on during simulation");
	force_on_a: assert property (@(posedge clk) disable iff (!rstn)
		auxForceOn |-> servoOnSignal)
		else $error("forced servo on not driven");
	volatile_mode_a: assert property (@(posedge clk) disable iff (!rstn)
		nvCommitEnable == (auxReg != 16'h0005))
		else $error("commit enable wrong");
	scope_timeout_a: assert property (@(posedge clk) disable iff (!rstn)
		timeoutDisable == (auxReg == 16'h0007))
		else $error("time out control wrong");
	backup_pulse_a: assert property (@(posedge clk) disable iff (!rstn)
		auxBackupWr |=> nvBackupPulse ##1 backupDisplay)
		else $error("backup not signalled");
	lockout_a: assert property (@(posedge clk) disable iff (!rstn)
		req.wr && hitAux && req.wdata == 16'h0001 && lockReg[1] |=> auxReg != 16'h0001)
		else $error("locked code accepted");
	range_reject_a: assert property (@(posedge clk) disable iff (!rstn)
		req.wr && hitResp && !respOk |=> $stable(respReg))
		else $error("out of range value stored");
	band_map_a: assert property (@(posedge clk) disable iff (!rstn)
		respReg > `SAT_BAND_HIGH |-> stiffnessBand == sat_pkg::SAT_BAND_XHIGH_S)
		else $error("stiffness band wrong");
	gain_copy_a: assert property (@(posedge clk) disable iff (!rstn)
		modeWr && modeNext == sat_pkg::SAT_TUNE_MANUAL && modeReg == sat_pkg::SAT_TUNE_AUTO
		|=> gainLoad && !gainLoadFull)
		else $error("gain copy-back wrong");
	semi_stable_a: assert property (@(posedge clk) disable iff (!rstn)
		semiDone |=> flagReg && inertiaStore && !estimatorRun)
		else $error("semi-auto stable handling wrong");
	excess_clear_a: assert property (@(posedge clk) disable iff (!rstn)
		modeReg == sat_pkg::SAT_TUNE_SEMI && inertiaExcess && !semiDone |=> !flagReg)
		else $error("flag not cleared on excess inertia");

endmodule

/* File: tb/sat_param_bank_tb.sv */
// Self-checking bench for the servo auxiliary and auto-tuning parameter bank.
// Assumes sat_pkg is compiled first and the bank runs with a short store period.
module sat_param_bank_tb;
	timeunit 1ns;
	timeprecision 1ps;

	// ------------------------------------------------------------------
	// Signals and instance
	// ------------------------------------------------------------------
	typedef struct packed {
		logic [15:0] addr;
		logic [15:0] data;
		logic        acc;
		logic [15:0] back;
	} sat_row_type;

	logic                  clk = 1'b0;
	logic                  rstn = 1'b0;
	sat_pkg::sat_req_type  req = '0;
	logic                  servoOnExt = 1'b0;
	logic [15:0]           speedCmd = 16'h0000;
	logic [15:0]           speedAct = 16'h0000;
	logic                  inertiaStable = 1'b0;
	logic                  inertiaExcess = 1'b0;
	logic [15:0]           inertiaEstimate = 16'h00aa;
	sat_pkg::sat_gain_type measuredGains = 64'h0001_0002_0003_0004;
	logic [15:0]           rdata, positionResponse, loadInertiaValue;
	logic                  rvalid, wrAck, wrReject, servoOnSignal, motorEnable, motorFaultMask;
	logic                  overspeedFault, nvCommitEnable, nvBackupPulse, backupDisplay;
	logic                  scopeMode, timeoutDisable, estimatorRun, inertiaStore;
	logic                  gainLoad, gainLoadFull;
	sat_pkg::sat_band_type stiffnessBand;
	int                    nErrors = 0;
	int                    numChecks = 0;
	sat_row_type           rows [13];
	logic [15:0]           bandVal [6] = '{16'h0032, 16'h0033, 16'h00fa, 16'h00fb, 16'h0352, 16'h0353};
	logic [15:0]           bandExp [6] = '{16'h0000, 16'h0001, 16'h0001, 16'h0002, 16'h0002, 16'h0003};

	// Short store period keeps the periodic inertia save inside the run
	sat_param_bank #(.STORE_CYCLES(20)) dut (
		.clk(clk), .rstn(rstn), .req(req), .rdata(rdata), .rvalid(rvalid),
		.wrAck(wrAck), .wrReject(wrReject), .servoOnExt(servoOnExt),
		.servoOnSignal(servoOnSignal), .motorEnable(motorEnable),
		.motorFaultMask(motorFaultMask), .speedCmd(speedCmd), .speedAct(speedAct),
		.overspeedFault(overspeedFault), .nvCommitEnable(nvCommitEnable),
		.nvBackupPulse(nvBackupPulse), .backupDisplay(backupDisplay), .scopeMode(scopeMode),
		.timeoutDisable(timeoutDisable), .stiffnessBand(stiffnessBand),
		.positionResponse(positionResponse), .estimatorRun(estimatorRun),
		.inertiaStable(inertiaStable), .inertiaExcess(inertiaExcess),
		.inertiaEstimate(inertiaEstimate), .loadInertiaValue(loadInertiaValue),
		.inertiaStore(inertiaStore), .measuredGains(measuredGains), .gainLoad(gainLoad),
		.gainLoadFull(gainLoadFull)
	);

	// 250 MHz clock
	always #2 clk = ~clk;

	// ------------------------------------------------------------------
	// Compare, bus and control tasks
	// ------------------------------------------------------------------
	task automatic check1(input logic got, input logic exp, input string what);
		numChecks++;
		if (got !== exp) begin
			nErrors++;
			$display("mismatch at %0t: %s got %b expected %b", $time, what, got, exp);
		end
	endtask

	task automatic check16(input logic [15:0] got, input logic [15:0] exp, input string what);
		numChecks++;
		if (got !== exp) begin
			nErrors++;
			$display("mismatch at %0t: %s got %h expected %h", $time, what, got, exp);
		end
	endtask

	// Write ends on the falling edge after the taking edge, so pulses are visible then
	task automatic wr(input logic [15:0] a, input logic [15:0] d, input logic acc);
		@(negedge clk);
		req.wr = 1'b1;
		req.addr = a;
		req.wdata = d;
		#1;
		check1(wrAck, acc, "write accept");
		check1(wrReject, !acc, "write refuse");
		@(negedge clk);
		req.wr = 1'b0;
	endtask

	// Read data arrives one edge after the strobe
	task automatic rd(input logic [15:0] a, input logic [15:0] exp);
		@(negedge clk);
		req.rd = 1'b1;
		req.addr = a;
		@(negedge clk);
		req.rd = 1'b0;
		check1(rvalid, 1'b1, "read valid");
		check16(rdata, exp, "read data");
	endtask

	// Reset stands for two clock cycles, released on a falling edge
	task automatic doReset();
		rstn = 1'b0;
		repeat (2) @(negedge clk);
		rstn = 1'b1;
	endtask

	task automatic done(input string name);
		$display("test %s finished at %0t", name, $time);
	endtask

	task automatic summarize();
		$display("checks %0d, mismatches %0d", numChecks, nErrors);
		if (nErrors == 0 && numChecks > 0) begin
			$display("Finished cleanly");
		end else begin
			$display("Finished with errors");
		end
		$finish;
	endtask

	// ------------------------------------------------------------------
	// Main sequence
	// ------------------------------------------------------------------
	initial begin
		rows[0]  = '{16'h023e, 16'h0064, 1'b1, 16'h0064};
		rows[1]  = '{16'h023e, 16'h0000, 1'b0, 16'h0064};
		rows[2]  = '{16'h023e, 16'h03e9, 1'b0, 16'h0064};
		rows[3]  = '{16'h023e, 16'h03e8, 1'b1, 16'h03e8};
		rows[4]  = '{16'h023e, 16'h0001, 1'b1, 16'h0001};
		rows[5]  = '{16'h0244, 16'h0000, 1'b0, 16'h1388};
		rows[6]  = '{16'h0244, 16'h1389, 1'b0, 16'h1388};
		rows[7]  = '{16'h0244, 16'h0005, 1'b1, 16'h0005};
		rows[8]  = '{16'h0240, 16'h0003, 1'b0, 16'h0000};
		rows[9]  = '{16'h0242, 16'h0002, 1'b0, 16'h0000};
		rows[10] = '{16'h023c, 16'h0009, 1'b0, 16'h0000};
		rows[11] = '{16'h023c, 16'hfff7, 1'b0, 16'h0000};
		rows[12] = '{16'h023d, 16'h0001, 1'b0, 16'h0000};
		doReset();
		// Reset values
		rd(16'h023c, 16'h0000);
		rd(16'h023e, 16'h0050);
		rd(16'h0240, 16'h0000);
		rd(16'h0242, 16'h0000);
		rd(16'h0244, 16'h1388);
		done("reset values");
		// Table of writes with readback, refusals leave the old value
		foreach (rows[i]) begin
			wr(rows[i].addr, rows[i].data, rows[i].acc);
			rd(rows[i].addr, rows[i].back);
		end
		done("write table");
		// Stiffness band edges
		foreach (bandVal[i]) begin
			wr(16'h023e, bandVal[i], 1'b1);
			check16({14'h0000, stiffnessBand}, bandExp[i], "band");
		end
		done("bands");
		// Speed error above the threshold of 5
		@(negedge clk);
		speedCmd = 16'h0006;
		@(negedge clk);
		check1(overspeedFault, 1'b1, "overspeed");
		speedCmd = 16'h0005;
		@(negedge clk);
		check1(overspeedFault, 1'b0, "speed at limit");
		done("overspeed");
		// Mode changes and gain copy-back
		wr(16'h0240, 16'h0001, 1'b1);
		check1(estimatorRun, 1'b1, "auto estimator");
		check16(positionResponse, 16'h0353, "position response");
		wr(16'h0240, 16'h0000, 1'b1);
		check1(gainLoad, 1'b1, "gain copy from auto");
		check1(gainLoadFull, 1'b0, "partial copy only");
		check16(positionResponse, 16'h0000, "manual response");
		wr(16'h0240, 16'h0002, 1'b1);
		wr(16'h0240, 16'h0000, 1'b1);
		check1(gainLoad, 1'b1, "gain copy from semi");
		check1(gainLoadFull, 1'b1, "full copy");
		done("mode changes");
		// Periodic inertia store in auto mode, bounded wait
		wr(16'h0240, 16'h0001, 1'b1);
		for (int n = 0; n <= 40 && inertiaStore !== 1'b1; n++) begin
			@(negedge clk);
			if (n == 40) begin
				check1(1'b0, 1'b1, "periodic store timeout");
				summarize();
			end
		end
		check16(loadInertiaValue, 16'h00aa, "periodic inertia");
		wr(16'h0240, 16'h0000, 1'b1);
		done("periodic store");
		// Semi-auto: stable estimate, excess, software restart
		inertiaEstimate = 16'h1234;
		wr(16'h0240, 16'h0002, 1'b1);
		check1(estimatorRun, 1'b1, "semi running");
		inertiaStable = 1'b1;
		@(negedge clk);
		inertiaStable = 1'b0;
		check1(inertiaStore, 1'b1, "semi store");
		check16(loadInertiaValue, 16'h1234, "semi inertia");
		check1(estimatorRun, 1'b0, "semi stopped");
		rd(16'h0242, 16'h0001);
		inertiaExcess = 1'b1;
		@(negedge clk);
		inertiaExcess = 1'b0;
		check1(estimatorRun, 1'b1, "excess resumes");
		rd(16'h0242, 16'h0000);
		wr(16'h0242, 16'h0001, 1'b1);
		check1(estimatorRun, 1'b0, "flag set stops");
		wr(16'h0242, 16'h0000, 1'b1);
		check1(estimatorRun, 1'b1, "flag clear restarts");
		done("semi auto");
		// Auxiliary function codes
		wr(16'h023c, 16'h0001, 1'b1);
		check1(servoOnSignal, 1'b1, "forced servo on");
		check1(motorEnable, 1'b1, "forced motor enable");
		wr(16'h023c, 16'h0005, 1'b1);
		check1(nvCommitEnable, 1'b0, "volatile mode");
		servoOnExt = 1'b1;
		speedCmd = 16'h0006;
		wr(16'h023c, 16'h0006, 1'b1);
		@(negedge clk);
		check1(servoOnSignal, 1'b0, "simulation servo off");
		check1(motorEnable, 1'b0, "simulation motor off");
		check1(motorFaultMask, 1'b1, "fault mask");
		check1(overspeedFault, 1'b0, "fault suppressed");
		speedCmd = 16'h0000;
		wr(16'h023c, 16'h0007, 1'b1);
		check1(scopeMode, 1'b1, "scope mode");
		check1(timeoutDisable, 1'b1, "time-out off");
		wr(16'h023c, 16'h0008, 1'b1);
		check1(nvBackupPulse, 1'b1, "backup pulse");
		@(negedge clk);
		check1(backupDisplay, 1'b1, "backup display");
		check1(nvBackupPulse, 1'b0, "backup pulse ends");
		servoOnExt = 1'b0;
		wr(16'h023c, 16'h0000, 1'b1);
		check1(servoOnSignal, 1'b0, "all off");
		check1(nvCommitEnable, 1'b1, "commit on");
		done("aux codes");
		// Lock-out codes refuse their positive partners
		for (int k = 0; k < 4; k++) begin
			logic [15:0] code;
			code = (k == 0) ? 16'h0001 : 16'h0004 + 16'(k);
			wr(16'h0000 - code, 16'h0000, 1'b0);
			wr(16'h023c, 16'h0000 - code, 1'b1);
			wr(16'h023c, code, 1'b0);
		end
		done("locks");
		// Second reset clears selector and locks
		doReset();
		rd(16'h023c, 16'h0000);
		wr(16'h023c, 16'h0001, 1'b1);
		done("second reset");
		summarize();
	end
endmodule
